/* File: logic/dbc_pkg.sv */
package dbc_pkg;
   // register byte offsets
   localparam logic [7:0] CFG_OFS = 8'h00;
   localparam logic [7:0] CTRL_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   // configuration field positions
   localparam int OUT0_BIT = 11;
   localparam int OUT1_BIT = 12;
   localparam int SYNC_RDY_BIT = 10;
   localparam int USER0_BIT = 8;
   localparam int USER1_BIT = 9;
   localparam int WAIT0_BIT = 6;
   localparam int WAIT1_BIT = 7;
   localparam int WIDTH_BIT = 5;
   // control and status field positions
   localparam int BUS_MODE_BIT = 0;
   localparam int BUSY_BIT = 0;
   localparam int MASTER_BIT = 1;
   localparam int DONE_CNT_LSB = 8;
   // values after reset
   localparam logic [1:0] PO_RST = 2'h0;
   localparam logic SYNC_RDY_RST = 1'b0;
   localparam logic [1:0] WC_RST = 2'h0;
   localparam logic WIDTH_RST = 1'b0;
   localparam logic BUS_MODE_RST = 1'b0;
   // least clocks of a memory cycle with an asynchronous ready
   localparam logic [2:0] ASYNC_MIN_CLKS = 3'h3;
   typedef enum {DBC_IDLE, DBC_T1, DBC_T2W, DBC_T2} dbc_state_e;
endpackage : dbc_pkg

/* File: logic/dbc_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module dbc_sync2 (
   input wire logic CLK,
   input wire logic RST,
   input wire logic d,
   output logic q
);
   logic s1_q;
   logic s1_d;
   logic s2_q;
   logic s2_d;

   always_comb begin
      s1_d = d;
      s2_d = s1_q;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
      end
   end

   assign q = s2_q;
endmodule : dbc_sync2
`default_nettype wire

/* File: logic/dbc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dbc_top (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic DMA_REQ,
   input wire logic HOLD_ACKNOWLEDGE,
   input wire logic BUS_GRANT_ACKNOWLEDGE,
   input wire logic READY_IN_N,
   input wire logic [1:0] DATA_SIZE_ACK_N,
   input wire logic [1:0] USER_PINS_I,
   output logic [1:0] USER_PINS_O,
   output logic [1:0] USER_PINS_OE,
   output logic BUS_REQ,
   output logic CYCLE_START,
   output logic CYCLE_DONE,
   output logic DATA_WIDTH_32
);
   // register state
   logic [1:0] po_q, po_d;
   logic sync_rdy_q, sync_rdy_d;
   logic [1:0] usr_q, usr_d;
   logic [1:0] wc_q, wc_d;
   logic width_q, width_d;
   logic bus_mode_q, bus_mode_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   // cycle state
   dbc_pkg::dbc_state_e st_q, st_d;
   logic [1:0] wait_q, wait_d;
   logic [2:0] clk_cnt_q, clk_cnt_d;
   logic [7:0] done_cnt_q, done_cnt_d;
   logic breq_q, breq_d;
   logic start_q, start_d;
   logic done_q, done_d;
   logic [1:0] uo_q, uo_d;
   logic [1:0] uoe_q, uoe_d;
   logic width_out_q, width_out_d;
   // ready path
   logic raw_ready;
   logic async_ready;
   logic cyc_ready;
   logic master;
   logic access;
   logic [31:0] cfg_rd;

   assign master = HOLD_ACKNOWLEDGE | BUS_GRANT_ACKNOWLEDGE;
   assign access = PSEL & PENABLE;

   assign raw_ready = bus_mode_q ? (DATA_SIZE_ACK_N != 2'h3) : ~READY_IN_N;

   dbc_sync2 u_rdy_sync (
      .CLK(CLK),
      .RST(RST),
      .d(raw_ready),
      .q(async_ready)
   );

   always_comb begin
      if (sync_rdy_q) begin
         cyc_ready = raw_ready;
      end else begin
         cyc_ready = async_ready && (clk_cnt_q >= dbc_pkg::ASYNC_MIN_CLKS);
      end
   end

   always_comb begin
      cfg_rd = 32'h0;
      cfg_rd[dbc_pkg::OUT1_BIT] = po_q[1];
      cfg_rd[dbc_pkg::OUT0_BIT] = po_q[0];
      cfg_rd[dbc_pkg::SYNC_RDY_BIT] = sync_rdy_q;
      cfg_rd[dbc_pkg::USER1_BIT] = usr_q[1];
      cfg_rd[dbc_pkg::USER0_BIT] = usr_q[0];
      cfg_rd[dbc_pkg::WAIT1_BIT] = wc_q[1];
      cfg_rd[dbc_pkg::WAIT0_BIT] = wc_q[0];
      cfg_rd[dbc_pkg::WIDTH_BIT] = width_q;
   end

   // register file and apb slave
   always_comb begin
      po_d = po_q;
      sync_rdy_d = sync_rdy_q;
      usr_d = usr_q;
      wc_d = wc_q;
      width_d = width_q;
      bus_mode_d = bus_mode_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      prdata_d = prdata_q;
      // answer one cycle into the access phase
      if (access && !pready_q) begin
         pready_d = 1'b1;
         prdata_d = 32'h0;
         if (PADDR == dbc_pkg::CFG_OFS) begin
            prdata_d = cfg_rd;
         end else if (PADDR == dbc_pkg::CTRL_OFS) begin
            prdata_d[dbc_pkg::BUS_MODE_BIT] = bus_mode_q;
         end else if (PADDR == dbc_pkg::STAT_OFS) begin
            prdata_d[dbc_pkg::BUSY_BIT] = (st_q != dbc_pkg::DBC_IDLE);
            prdata_d[dbc_pkg::MASTER_BIT] = master;
            prdata_d[dbc_pkg::DONE_CNT_LSB +: 8] = done_cnt_q;
         end else begin
            pslverr_d = 1'b1;
         end
      end
      if (access && pready_q && PWRITE) begin
         if (PADDR == dbc_pkg::CFG_OFS) begin
            po_d = {PWDATA[dbc_pkg::OUT1_BIT], PWDATA[dbc_pkg::OUT0_BIT]};
            sync_rdy_d = PWDATA[dbc_pkg::SYNC_RDY_BIT];
            wc_d = {PWDATA[dbc_pkg::WAIT1_BIT], PWDATA[dbc_pkg::WAIT0_BIT]};
            width_d = PWDATA[dbc_pkg::WIDTH_BIT];
         end else if (PADDR == dbc_pkg::CTRL_OFS) begin
            bus_mode_d = PWDATA[dbc_pkg::BUS_MODE_BIT];
         end
      end
      // last reset cycle sets the pin status
      if (RST) begin
         usr_d = USER_PINS_I;
      end
   end

   always_ff @(posedge CLK) begin
      usr_q <= usr_d;
      if (RST) begin
         po_q <= dbc_pkg::PO_RST;
         sync_rdy_q <= dbc_pkg::SYNC_RDY_RST;
         wc_q <= dbc_pkg::WC_RST;
         width_q <= dbc_pkg::WIDTH_RST;
         bus_mode_q <= dbc_pkg::BUS_MODE_RST;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end else begin
         po_q <= po_d;
         sync_rdy_q <= sync_rdy_d;
         wc_q <= wc_d;
         width_q <= width_d;
         bus_mode_q <= bus_mode_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end

   // dma cycle sequencer
   always_comb begin
      st_d = st_q;
      wait_d = wait_q;
      clk_cnt_d = clk_cnt_q;
      done_cnt_d = done_cnt_q;
      start_d = 1'b0;
      done_d = 1'b0;
      breq_d = DMA_REQ | (st_q != dbc_pkg::DBC_IDLE);
      if (clk_cnt_q != 3'h7) begin
         clk_cnt_d = clk_cnt_q + 3'h1;
      end
      case (st_q)
         dbc_pkg::DBC_IDLE: begin
            if (DMA_REQ && master) begin
               st_d = dbc_pkg::DBC_T1;
               start_d = 1'b1;
               clk_cnt_d = 3'h1;
            end
         end
         dbc_pkg::DBC_T1: begin
            wait_d = wc_q;
            if (wc_q != 2'h0) begin
               st_d = dbc_pkg::DBC_T2W;
            end else begin
               st_d = dbc_pkg::DBC_T2;
            end
         end
         dbc_pkg::DBC_T2W: begin
            wait_d = wait_q - 2'h1;
            if (wait_q == 2'h1) begin
               st_d = dbc_pkg::DBC_T2;
            end
         end
         dbc_pkg::DBC_T2: begin
            if (cyc_ready) begin
               done_d = 1'b1;
               done_cnt_d = done_cnt_q + 8'h1;
               if (DMA_REQ && master) begin
                  st_d = dbc_pkg::DBC_T1;
                  start_d = 1'b1;
                  clk_cnt_d = 3'h1;
               end else begin
                  st_d = dbc_pkg::DBC_IDLE;
               end
            end
         end
         default: begin
            st_d = dbc_pkg::DBC_IDLE;
         end
      endcase
      // user pins follow output bits while master
      uo_d = master ? po_q : 2'h0;
      uoe_d = master ? 2'h3 : 2'h0;
      width_out_d = width_q;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         st_q <= dbc_pkg::DBC_IDLE;
         wait_q <= 2'h0;
         clk_cnt_q <= 3'h0;
         done_cnt_q <= 8'h0;
         breq_q <= 1'b0;
         start_q <= 1'b0;
         done_q <= 1'b0;
         uo_q <= 2'h0;
         uoe_q <= 2'h0;
         width_out_q <= dbc_pkg::WIDTH_RST;
      end else begin
         st_q <= st_d;
         wait_q <= wait_d;
         clk_cnt_q <= clk_cnt_d;
         done_cnt_q <= done_cnt_d;
         breq_q <= breq_d;
         start_q <= start_d;
         done_q <= done_d;
         uo_q <= uo_d;
         uoe_q <= uoe_d;
         width_out_q <= width_out_d;
      end
   end

   assign PRDATA = prdata_q;
   assign PREADY = pready_q;
   assign PSLVERR = pslverr_q;
   assign USER_PINS_O = uo_q;
   assign USER_PINS_OE = uoe_q;
   assign BUS_REQ = breq_q;
   assign CYCLE_START = start_q;
   assign CYCLE_DONE = done_q;
   assign DATA_WIDTH_32 = width_out_q;
endmodule : dbc_top
`default_nettype wire

/* File: bench/dbc_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dbc_mem_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic done,
   input wire logic [1:0] dly,
   output logic rdy_n
);
   logic act_q, act_d;
   logic [1:0] cnt_q, cnt_d;
   always_comb begin
      act_d = ~rst & (start | (act_q & ~done));
      cnt_d = start ? dly : cnt_q - {1'b0, cnt_q != 2'h0};
   end
   always_ff @(posedge clk) begin
      act_q <= act_d;
      cnt_q <= cnt_d;
   end
   assign rdy_n = ~(act_q & (cnt_q == 2'h0));
endmodule : dbc_mem_model
`default_nettype wire

/* File: bench/dbc_props.sv */
`timescale 1ns/1ps
`default_nettype none
module dbc_props (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic HOLD_ACKNOWLEDGE,
   input wire logic BUS_GRANT_ACKNOWLEDGE,
   input wire logic [1:0] USER_PINS_OE,
   input wire logic CYCLE_START,
   input wire logic CYCLE_DONE
);
   wire logic mst = HOLD_ACKNOWLEDGE | BUS_GRANT_ACKNOWLEDGE;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   property p_wait; $rose(PENABLE) |-> !PREADY ##1 PREADY; endproperty
   a_wait: assert property (p_wait) else $error("apb wait");
   property p_rdy; PREADY |=> !PREADY; endproperty
   a_rdy: assert property (p_rdy) else $error("pready width");
   property p_oe_on; mst && !$past(RST) |=> USER_PINS_OE == 2'h3; endproperty
   a_oe_on: assert property (p_oe_on) else $error("oe on");
   property p_oe_off; !mst |=> USER_PINS_OE == 2'h0; endproperty
   a_oe_off: assert property (p_oe_off) else $error("oe off");
   property p_gap; CYCLE_START |=> !CYCLE_START && !CYCLE_DONE; endproperty
   a_gap: assert property (p_gap) else $error("short cycle");
   property p_done; CYCLE_DONE |=> !CYCLE_DONE; endproperty
   a_done: assert property (p_done) else $error("done width");
   property p_end; CYCLE_START |-> ##[2:12] CYCLE_DONE; endproperty
   a_end: assert property (p_end) else $error("no done");
   property p_mst; CYCLE_START |-> $past(mst); endproperty
   a_mst: assert property (p_mst) else $error("start w/o master");
   c_done: cover property (CYCLE_DONE);
   c_rdy: cover property (PREADY);
   c_mst: cover property ($rose(mst));
endmodule : dbc_props
bind dbc_top dbc_props u_dbc_props (.CLK, .RST, .PENABLE, .PREADY,
   .HOLD_ACKNOWLEDGE, .BUS_GRANT_ACKNOWLEDGE, .USER_PINS_OE, .CYCLE_START,
   .CYCLE_DONE);
`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic CLK = 1'b0;
   logic RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, DMA_REQ, READY_IN_N;
   logic HOLD_ACKNOWLEDGE, BUS_GRANT_ACKNOWLEDGE, BUS_REQ, CYCLE_START;
   logic CYCLE_DONE, DATA_WIDTH_32, rdy_n, bm;
   logic [1:0] DATA_SIZE_ACK_N, USER_PINS_I, USER_PINS_O, USER_PINS_OE;
   logic [1:0] dly, pins;
   logic [7:0] PADDR, rnd;
   logic [31:0] PWDATA, PRDATA, cfg;
   logic [3:0] len, e;
   logic [32:0] q_rd[$];
   logic [3:0] q_len[$];
   int mismatches = 0;
   int check_count = 0;
   always #25 CLK = ~CLK;
   // unused ready source held active so a wrong pick shortens the cycle
   assign READY_IN_N = bm ? 1'b0 : rdy_n;
   assign DATA_SIZE_ACK_N = bm ? {rdy_n, 1'b1} : 2'h0;
   dbc_top u_dbc_top (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
      .PRDATA, .PREADY, .PSLVERR, .DMA_REQ, .HOLD_ACKNOWLEDGE,
      .BUS_GRANT_ACKNOWLEDGE, .READY_IN_N, .DATA_SIZE_ACK_N, .USER_PINS_I,
      .USER_PINS_O, .USER_PINS_OE, .BUS_REQ, .CYCLE_START, .CYCLE_DONE,
      .DATA_WIDTH_32);
   dbc_mem_model u_dbc_mem_model (.clk(CLK), .rst(RST), .start(CYCLE_START),
      .done(CYCLE_DONE), .dly(dly), .rdy_n(rdy_n));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish;
      if (mismatches == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      do @(posedge CLK); while (PREADY !== 1'b1);
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [32:0] exp);
      q_rd.push_back(exp);
      apb(1'b0, a, 32'h0);
   endtask : rd
   always @(posedge CLK) begin
      if (PREADY === 1'b1 && !PWRITE && q_rd.size() > 0)
         check({PSLVERR, PRDATA}, q_rd.pop_front());
      if (CYCLE_DONE === 1'b1 && q_len.size() > 0) begin
         e = q_len.pop_front();
         check(e != 0 ? 33'(len) : 33'(len >= 4'h3), e != 0 ? 33'(e) : 33'h1);
      end
      len = CYCLE_START ? 4'h1 : len + 4'h1;
   end
   initial begin
      {RST, PSEL, PENABLE, PWRITE, DMA_REQ, bm} = 6'h20;
      {HOLD_ACKNOWLEDGE, BUS_GRANT_ACKNOWLEDGE, PADDR, PWDATA} = '0;
      {USER_PINS_I, dly, rnd} = 12'h05f;
      @(posedge CLK);
      for (int k = 0; k < 2; k++) begin
         rnd = lfsr(rnd);
         pins = rnd[1:0];
         RST <= 1'b1;
         USER_PINS_I <= pins;
         repeat (3) @(posedge CLK);
         RST <= 1'b0;
         @(posedge CLK);
         USER_PINS_I <= ~pins;
         rd(dbc_pkg::CFG_OFS, {23'h0, pins, 8'h0});
      end
      for (int i = 0; i < 16; i++) begin
         rnd = lfsr(rnd);
         cfg = {19'h0, rnd[1:0], i[3], 2'h0, i[1:0], rnd[2], 5'h0};
         dly = rnd[7:6];
         apb(1'b1, dbc_pkg::CFG_OFS, cfg);
         apb(1'b1, dbc_pkg::CTRL_OFS, {31'h0, i[2]});
         bm <= i[2];
         rd(dbc_pkg::CTRL_OFS, {32'h0, i[2]});
         rd(dbc_pkg::CFG_OFS, {1'b0, cfg | {22'h0, pins, 8'h0}});
         HOLD_ACKNOWLEDGE <= rnd[3];
         BUS_GRANT_ACKNOWLEDGE <= !rnd[3];
         repeat (2) @(posedge CLK);
         check({USER_PINS_O, USER_PINS_OE, DATA_WIDTH_32}, {rnd[1:0], 2'h3, rnd[2]});
         q_len.push_back(i[3] ? 4'h2 + 4'(i[1:0] > dly ? i[1:0] : dly) : 4'h0);
         DMA_REQ <= 1'b1;
         do @(posedge CLK); while (CYCLE_START !== 1'b1);
         check(33'(BUS_REQ), 33'h1);
         DMA_REQ <= 1'b0;
         do @(posedge CLK); while (CYCLE_DONE !== 1'b1);
         HOLD_ACKNOWLEDGE <= 1'b0;
         BUS_GRANT_ACKNOWLEDGE <= 1'b0;
         repeat (2) @(posedge CLK);
         check(33'({USER_PINS_OE, BUS_REQ}), 33'h0);
      end
      // sixteen completed cycles, idle, no master
      rd(dbc_pkg::STAT_OFS, {1'b0, 32'h1000});
      rd(8'h0c, {1'b1, 32'h0});
      tally_and_finish();
   end
   initial begin
      repeat (5000) @(posedge CLK);
      mismatches++;
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
